// File: hdl/step_seq_pkg.sv
// Purpose: Shared constants, types and tables of the step clock sequencer
// Assumes: 40 MHz system clock
// Notes:   Times are in ns; cycle counts derive from the clock period
package step_seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEL_FILT_NS   = 1250;
  localparam int HOME_FILT_NS  = 625;
  localparam int WAKE_NS       = 7500;
  localparam int SEL_FILT_CYC  = (SEL_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOME_FILT_CYC = (HOME_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] SEL_FILT_LAST  = 6'(SEL_FILT_CYC - 1);
  localparam logic [5:0] HOME_FILT_LAST = 6'(HOME_FILT_CYC - 1);
  localparam logic [8:0] WAKE_LAST      = 9'(WAKE_CYC - 1);

  // ----------------------------------------------------------------
  // Angle and current
  // ----------------------------------------------------------------
  localparam logic [6:0] HOME_ANGLE   = 7'h10;
  localparam logic [6:0] CURRENT_FULL = 7'h64;
  localparam logic [6:0] SINE_TBL [0:32] = '{
    7'h00, 7'h05, 7'h0a, 7'h0f, 7'h14, 7'h19, 7'h1d, 7'h22, 7'h26, 7'h2b, 7'h2f,
    7'h34, 7'h38, 7'h3c, 7'h3f, 7'h43, 7'h47, 7'h4a, 7'h4d, 7'h50, 7'h53, 7'h56,
    7'h58, 7'h5a, 7'h5c, 7'h5e, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64, 7'h64};

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] STATUS_OFS     = 12'h004;
  localparam logic [11:0] SETPOINT_OFS   = 12'h008;
  localparam logic [11:0] STEP_COUNT_OFS = 12'h00c;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_HOME_BIT = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RES_STANDBY   = 3'b000,
    RES_FULL      = 3'b001,
    RES_HALF_A    = 3'b010,
    RES_QUARTER   = 3'b011,
    RES_HALF_B    = 3'b100,
    RES_EIGHTH    = 3'b101,
    RES_SIXTEENTH = 3'b110,
    RES_32ND      = 3'b111
  } res_t;

  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_WAKING  = 2'b01,
    PWR_RUN     = 2'b10
  } pwr_t;

  typedef struct packed {
    logic step_clk;
    logic direction_select;
    logic resolution_sel0;
    logic resolution_sel1;
    logic resolution_sel2;
    logic enable;
    logic angle_reset;
  } pins_t;

  typedef struct packed {
    logic       neg;
    logic [6:0] mag;
  } setpoint_t;

endpackage : step_seq_pkg

// File: hdl/step_clock_sequencer.sv
// Purpose: Step and direction sequencer for a two-phase bipolar motor bridge
// Assumes: Pins are asynchronous to sys_clk_in
// Notes:   APB slave for status and control; rules listed below
`timescale 1ns/100ps

module step_clock_sequencer (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic [11:0]             paddr_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  input  wire step_seq_pkg::pins_t     pins_in,
  output step_seq_pkg::setpoint_t      phase_a_current_out,
  output step_seq_pkg::setpoint_t      phase_b_current_out,
  output logic                         bridge_a_pos_out,
  output logic                         bridge_a_neg_out,
  output logic                         bridge_a_oe_out,
  output logic                         bridge_b_pos_out,
  output logic                         bridge_b_neg_out,
  output logic                         bridge_b_oe_out,
  output logic                         home_angle_monitor_n_out,
  output logic                         home_angle_monitor_n_oe_out,
  output logic                         internal_oscillator_en_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic step_seq_pkg::setpoint_t phase_set(input logic [6:0] ang,
                                                        input step_seq_pkg::res_t r);
    logic [5:0]              idx;
    step_seq_pkg::setpoint_t sp;
    idx    = ang[5] ? (6'd32 - {1'b0, ang[4:0]}) : {1'b0, ang[4:0]};
    sp.neg = ang[6];
    sp.mag = step_seq_pkg::SINE_TBL[idx];
    // Half (a) and full run at full current on every energised phase
    if ((r == step_seq_pkg::RES_HALF_A || r == step_seq_pkg::RES_FULL) && sp.mag != 7'h00) begin
      sp.mag = step_seq_pkg::CURRENT_FULL;
    end
    return sp;
  endfunction : phase_set

  function automatic logic [6:0] step_inc(input step_seq_pkg::res_t r);
    case (r)
      step_seq_pkg::RES_32ND:      return 7'h01;
      step_seq_pkg::RES_SIXTEENTH: return 7'h02;
      step_seq_pkg::RES_EIGHTH:    return 7'h04;
      step_seq_pkg::RES_QUARTER:   return 7'h08;
      step_seq_pkg::RES_HALF_A:    return 7'h10;
      step_seq_pkg::RES_HALF_B:    return 7'h10;
      step_seq_pkg::RES_FULL:      return 7'h20;
      default:                     return 7'h00;
    endcase
  endfunction : step_inc

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A change counts once the second and third stages agree
  step_seq_pkg::pins_t sync1_r, sync2_r, sync3_r, pin_r, pin_nxt, pin_prev_r;

  assign pin_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (pin_r & (sync2_r ^ sync3_r));

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      sync3_r    <= '0;
      pin_r      <= '0;
      pin_prev_r <= '0;
    end else begin
      sync1_r    <= pins_in;
      sync2_r    <= sync1_r;
      sync3_r    <= sync2_r;
      pin_r      <= pin_nxt;
      pin_prev_r <= pin_r;
    end
  end

  // ----------------------------------------------------------------
  // Digital filters for resolution selects and angle reset
  // ----------------------------------------------------------------
  logic [2:0]         sel_pin;
  logic               sel_diff;
  logic               home_diff;
  logic [5:0]         sel_cnt_r;
  logic [5:0]         home_cnt_r;
  step_seq_pkg::res_t res_r;
  logic               home_filt_r;

  assign sel_pin   = {pin_r.resolution_sel0, pin_r.resolution_sel1, pin_r.resolution_sel2};
  assign sel_diff  = (sel_pin != res_r) && (pin_r[4:2] == pin_prev_r[4:2]);
  assign home_diff = (pin_r.angle_reset != home_filt_r);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_cnt_r   <= 6'h00;
      home_cnt_r  <= 6'h00;
      res_r       <= step_seq_pkg::RES_STANDBY;
      home_filt_r <= 1'b0;
    end else begin
      sel_cnt_r <= (sel_diff && sel_cnt_r != step_seq_pkg::SEL_FILT_LAST) ?
                   sel_cnt_r + 6'h01 : 6'h00;
      if (sel_diff && sel_cnt_r == step_seq_pkg::SEL_FILT_LAST) begin
        res_r <= step_seq_pkg::res_t'(sel_pin);
      end
      home_cnt_r <= (home_diff && home_cnt_r != step_seq_pkg::HOME_FILT_LAST) ?
                    home_cnt_r + 6'h01 : 6'h00;
      if (home_diff && home_cnt_r == step_seq_pkg::HOME_FILT_LAST) begin
        home_filt_r <= pin_r.angle_reset;
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby and wake-up
  // ----------------------------------------------------------------
  step_seq_pkg::pwr_t pwr_r, pwr_nxt;
  logic [8:0]         wake_cnt_r;

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      step_seq_pkg::PWR_STANDBY: begin
        if (res_r != step_seq_pkg::RES_STANDBY) begin
          pwr_nxt = step_seq_pkg::PWR_WAKING;
        end
      end
      step_seq_pkg::PWR_WAKING: begin
        if (res_r == step_seq_pkg::RES_STANDBY) begin
          pwr_nxt = step_seq_pkg::PWR_STANDBY;
        end else if (wake_cnt_r == step_seq_pkg::WAKE_LAST) begin
          pwr_nxt = step_seq_pkg::PWR_RUN;
        end
      end
      step_seq_pkg::PWR_RUN: begin
        if (res_r == step_seq_pkg::RES_STANDBY) begin
          pwr_nxt = step_seq_pkg::PWR_STANDBY;
        end
      end
      default: pwr_nxt = step_seq_pkg::PWR_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_r      <= step_seq_pkg::PWR_STANDBY;
      wake_cnt_r <= 9'h000;
    end else begin
      pwr_r      <= pwr_nxt;
      wake_cnt_r <= (pwr_r == step_seq_pkg::PWR_WAKING) ? wake_cnt_r + 9'h001 : 9'h000;
    end
  end

  // ----------------------------------------------------------------
  // Electrical angle
  // ----------------------------------------------------------------
  logic [1:0]  ctrl_r;
  logic [6:0]  angle_r, angle_nxt;
  logic [15:0] step_count_r;
  logic [6:0]  inc, base, off, up_amt, dn_amt, stepped;
  logic        step_rise, step_go, home_force, running;

  assign running    = (pwr_r == step_seq_pkg::PWR_RUN);
  assign step_rise  = pin_r.step_clk & ~pin_prev_r.step_clk;
  assign step_go    = step_rise & running & ~ctrl_r[step_seq_pkg::CTRL_HOLD_BIT];
  assign home_force = home_filt_r | ctrl_r[step_seq_pkg::CTRL_HOME_BIT];
  assign inc        = step_inc(res_r);
  // full step grid sits on odd multiples of 45 degrees, finer grids include zero
  assign base       = (res_r == step_seq_pkg::RES_FULL) ? step_seq_pkg::HOME_ANGLE : 7'h00;
  assign off        = (angle_r - base) & (inc - 7'h01);
  assign up_amt     = (off != 7'h00) ? inc - off : inc;
  assign dn_amt     = (off != 7'h00) ? off : inc;
  // counting up makes phase A lead, down makes phase B lead
  assign stepped    = pin_r.direction_select ? angle_r + up_amt : angle_r - dn_amt;
  assign angle_nxt  = home_force ? step_seq_pkg::HOME_ANGLE : (step_go ? stepped : angle_r);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      angle_r      <= step_seq_pkg::HOME_ANGLE;
      step_count_r <= 16'h0000;
    end else begin
      angle_r      <= angle_nxt;
      step_count_r <= step_count_r + {15'h0000, step_go};
    end
  end

  // ----------------------------------------------------------------
  // Set points, bridges and monitor
  // ----------------------------------------------------------------
  step_seq_pkg::setpoint_t sp_a, sp_b;
  logic                    drive_on;

  // phase A is cosine, phase B sine of the angle
  // 45 degrees gives 71 or 100 percent by resolution
  assign sp_a     = phase_set(angle_r + 7'h20, res_r);
  assign sp_b     = phase_set(angle_r, res_r);
  assign drive_on = pin_r.enable & running;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_a_current_out         <= '0;
      phase_b_current_out         <= '0;
      bridge_a_pos_out            <= 1'b0;
      bridge_a_neg_out            <= 1'b0;
      bridge_a_oe_out             <= 1'b0;
      bridge_b_pos_out            <= 1'b0;
      bridge_b_neg_out            <= 1'b0;
      bridge_b_oe_out             <= 1'b0;
      home_angle_monitor_n_out    <= 1'b0;
      home_angle_monitor_n_oe_out <= 1'b0;
      internal_oscillator_en_out  <= 1'b0;
    end else begin
      phase_a_current_out         <= sp_a;
      phase_b_current_out         <= sp_b;
      bridge_a_pos_out            <= pin_r.direction_select ^ sp_a.neg;
      bridge_a_neg_out            <= ~(pin_r.direction_select ^ sp_a.neg);
      bridge_a_oe_out             <= drive_on;
      bridge_b_pos_out            <= pin_r.direction_select ^ sp_b.neg;
      bridge_b_neg_out            <= ~(pin_r.direction_select ^ sp_b.neg);
      bridge_b_oe_out             <= drive_on;
      // open drain low at initial angle
      home_angle_monitor_n_oe_out <= (angle_r == step_seq_pkg::HOME_ANGLE);
      internal_oscillator_en_out  <= (pwr_r != step_seq_pkg::PWR_STANDBY);
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: read data is captured on the same edge that raises pready
  logic        access, wr_en, sel_ctrl, sel_stat, sel_sp, sel_cnt, mapped;
  logic [31:0] rd_data;

  assign access   = psel_in & penable_in;
  assign sel_ctrl = (paddr_in == step_seq_pkg::CTRL_OFS);
  assign sel_stat = (paddr_in == step_seq_pkg::STATUS_OFS);
  assign sel_sp   = (paddr_in == step_seq_pkg::SETPOINT_OFS);
  assign sel_cnt  = (paddr_in == step_seq_pkg::STEP_COUNT_OFS);
  assign mapped   = sel_ctrl | sel_stat | sel_sp | sel_cnt;
  assign wr_en    = access & pready_out & pwrite_in & sel_ctrl;
  assign rd_data  = sel_ctrl ? {30'h00000000, ctrl_r} :
                    sel_stat ? {13'h0000, home_filt_r, pin_r.direction_select, pin_r.enable,
                                1'b0, res_r, 2'h0, pwr_r, 1'b0, angle_r} :
                    sel_sp   ? {16'h0000, sp_b, sp_a} :
                    sel_cnt  ? {16'h0000, step_count_r} : 32'h00000000;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
      ctrl_r      <= step_seq_pkg::CTRL_RESET;
    end else begin
      pready_out <= access & ~pready_out;
      if (access && !pready_out) begin
        pslverr_out <= ~mapped | (pwrite_in & ~sel_ctrl);
        prdata_out  <= pwrite_in ? 32'h00000000 : rd_data;
      end
      if (wr_en) begin
        ctrl_r <= pwdata_in[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_step_advances: assert property (step_go && !home_force |=> angle_r != $past(angle_r))
    else $error("Accepted step did not move the angle");
  a_no_stray_move: assert property (!step_go && !home_force |=> $stable(angle_r))
    else $error("Angle moved without a rising step edge");
  a_enable_off: assert property (!pin_r.enable |=> !bridge_a_oe_out && !bridge_b_oe_out)
    else $error("Bridge driven while enable low");
  a_charge_polarity: assert property (running && pin_r.enable && angle_r == 7'h10 &&
    pin_r.direction_select |=> bridge_a_pos_out && !bridge_a_neg_out && bridge_b_pos_out)
    else $error("Charge start polarity wrong");
  a_standby_osc: assert property (pwr_r == step_seq_pkg::PWR_STANDBY |=>
    !internal_oscillator_en_out && !bridge_a_oe_out)
    else $error("Oscillator or bridge active in standby");
  a_wake_hold: assert property ($rose(pwr_r == step_seq_pkg::PWR_WAKING) |->
    (pwr_r != step_seq_pkg::PWR_RUN && !step_go) [*8])
    else $error("Stepping allowed during wake-up");
  a_sel_filter: assert property ($changed(sel_pin) |=> $stable(res_r) [*8])
    else $error("Resolution changed before filter time");
  a_home_filter: assert property ($rose(pin_r.angle_reset) && !home_filt_r |=>
    !home_filt_r [*8])
    else $error("Angle reset acted before filter time");
  a_home_force: assert property (home_filt_r |=> angle_r == 7'h10)
    else $error("Angle not held at initial value");
  a_monitor_low: assert property ((angle_r == 7'h10) |=> home_angle_monitor_n_oe_out)
    else $error("Monitor not pulled low at initial angle");
  a_monitor_free: assert property ((angle_r != 7'h10) |=> !home_angle_monitor_n_oe_out)
    else $error("Monitor pulled low away from initial angle");
  a_init_current: assert property (angle_r == 7'h10 && res_r == step_seq_pkg::RES_32ND |=>
    phase_a_current_out.mag == 7'h47 && phase_b_current_out.mag == 7'h47)
    else $error("Initial set point not 71 percent");

endmodule : step_clock_sequencer

// File: verif/step_host_model.sv
// Purpose: Host controller model driving the step, direction and mode pins
// Assumes: Pins change right after a rising clock edge
// Notes:   Wait counts cover pin sync plus the digital filters
`timescale 1ns/100ps

module step_host_model (
  input  wire logic           clk_in,
  output step_seq_pkg::pins_t pins_out
);
  // ----------------------------------------------------------------
  // Pin driving
  // ----------------------------------------------------------------
  // enable low while supply ramps
  initial pins_out = '0;

  task automatic drive_sel(input logic [2:0] s, input int settle);
    @(posedge clk_in);
    pins_out.resolution_sel0 <= s[2];
    pins_out.resolution_sel1 <= s[1];
    pins_out.resolution_sel2 <= s[0];
    repeat (settle) @(posedge clk_in);
  endtask : drive_sel

  // hold off other inputs during wake-up
  task automatic wake(input logic [2:0] s);
    drive_sel(s, 420);
  endtask : wake

  // Each phase stays 4 cycles so the sync stage sees it
  task automatic pulse_step(input logic dir);
    @(posedge clk_in);
    pins_out.direction_select <= dir;
    @(posedge clk_in);
    pins_out.step_clk <= 1'b1;
    repeat (4) @(posedge clk_in);
    pins_out.step_clk <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : pulse_step

  task automatic set_lines(input logic en, input logic home, input int settle);
    @(posedge clk_in);
    pins_out.enable      <= en;
    pins_out.angle_reset <= home;
    repeat (settle) @(posedge clk_in);
  endtask : set_lines
endmodule : step_host_model

// File: verif/step_clock_sequencer_tb.sv
// Purpose: Self-checking bench of the step clock sequencer
// Assumes: 40 MHz clock; host model drives all motor pins
// Notes:   Angle is read back through the status register
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end

module step_clock_sequencer_tb;
  logic                    sys_clk_in;
  logic                    rst_n_in;
  logic                    psel_in;
  logic                    penable_in;
  logic                    pwrite_in;
  logic [11:0]             paddr_in;
  logic [31:0]             pwdata_in;
  logic [31:0]             prdata_out;
  logic [31:0]             st;
  logic                    pready_out;
  logic                    pslverr_out;
  logic                    err;
  step_seq_pkg::pins_t     pins;
  step_seq_pkg::setpoint_t pa;
  step_seq_pkg::setpoint_t pb;
  logic                    a_pos, a_neg, a_oe, b_pos, b_neg, b_oe, mon, mon_oe, osc;
  int                      miscompares = 0;
  int                      checks_done = 0;
  int                      cyc = 0;
  // Open-drain monitor with its pull-up
  wire                     mon_wire = mon_oe ? mon : 1'b1;

  step_host_model u_host (.clk_in(sys_clk_in), .pins_out(pins));

  step_clock_sequencer u_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pins_in(pins), .phase_a_current_out(pa),
    .phase_b_current_out(pb), .bridge_a_pos_out(a_pos), .bridge_a_neg_out(a_neg),
    .bridge_a_oe_out(a_oe), .bridge_b_pos_out(b_pos), .bridge_b_neg_out(b_neg),
    .bridge_b_oe_out(b_oe), .home_angle_monitor_n_out(mon),
    .home_angle_monitor_n_oe_out(mon_oe), .internal_oscillator_en_out(osc));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------------------------------
  // Bus and report
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic e);
    @(posedge sys_clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    e  = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic stat();
    apb(1'b0, step_seq_pkg::STATUS_OFS, '0, st, err);
  endtask : stat

  task automatic give_verdict();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    stat();
    `CHK(st[9:0], 10'h010)
    `CHK({mon_wire, osc, pa.mag}, {2'b00, 7'h47})
    apb(1'b1, step_seq_pkg::CTRL_OFS, 32'h3, st, err);
    apb(1'b0, step_seq_pkg::CTRL_OFS, '0, st, err);
    `CHK(st, 32'h3)
    apb(1'b1, step_seq_pkg::CTRL_OFS, 32'h0, st, err);
    apb(1'b0, 12'h010, '0, st, err);
    `CHK({err, st}, 33'h1_0000_0000)
    apb(1'b1, step_seq_pkg::STATUS_OFS, 32'h1, st, err);
    `CHK(err, 1'b1)
  endtask : t_reset

  task automatic t_run();
    u_host.set_lines(1'b1, 1'b0, 4);
    u_host.wake(3'b111);
    stat();
    `CHK({st[9:8], osc, a_oe}, 4'hb)
    u_host.pulse_step(1'b1);
    stat();
    `CHK(st[6:0], 7'h11)
    `CHK({pa.mag, pb.mag, mon_wire, a_pos}, {7'h43, 7'h4a, 2'b11})
    u_host.pulse_step(1'b0);
    u_host.pulse_step(1'b0);
    stat();
    `CHK({st[6:0], pa.mag, pb.mag}, {7'h0f, 7'h4a, 7'h43})
    `CHK({a_pos, a_neg, b_pos, b_neg}, 4'b0101)
    u_host.set_lines(1'b0, 1'b0, 10);
    `CHK({a_oe, b_oe}, 2'b00)
    u_host.set_lines(1'b1, 1'b0, 10);
    `CHK({a_oe, b_oe}, 2'b11)
  endtask : t_run

  task automatic t_res_table();
    logic [6:0] inc [1:7] = '{7'h20, 7'h10, 7'h08, 7'h10, 7'h04, 7'h02, 7'h01};
    for (int i = 1; i < 8; i++) begin
      u_host.drive_sel(3'(i), 70);
      stat();
      `CHK(st[14:12], 3'(i))
      u_host.set_lines(1'b1, 1'b1, 40);
      u_host.pulse_step(1'b1);
      stat();
      `CHK(st[6:0], 7'h10)
      `CHK({pa.mag, pb.mag}, (i < 3) ? {2{7'h64}} : {2{7'h47}})
      u_host.set_lines(1'b1, 1'b0, 40);
      u_host.pulse_step(1'b1);
      stat();
      `CHK(st[6:0], 7'h10 + inc[i])
    end
  endtask : t_res_table

  task automatic t_nearest_and_filter();
    u_host.drive_sel(3'b001, 70);
    u_host.pulse_step(1'b1);
    stat();
    `CHK(st[6:0], 7'h30)
    `CHK({pa.neg, pb.neg, a_pos, a_neg, b_pos, b_neg}, 6'b100110)
    apb(1'b1, step_seq_pkg::CTRL_OFS, 32'h2, st, err);
    apb(1'b1, step_seq_pkg::CTRL_OFS, 32'h0, st, err);
    u_host.drive_sel(3'b111, 70);
    // Short glitches must not reach the angle logic
    u_host.drive_sel(3'b110, 20);
    u_host.drive_sel(3'b111, 70);
    u_host.pulse_step(1'b1);
    u_host.set_lines(1'b1, 1'b1, 10);
    u_host.set_lines(1'b1, 1'b0, 40);
    stat();
    `CHK({st[14:12], st[6:0]}, {3'b111, 7'h11})
  endtask : t_nearest_and_filter

  task automatic t_standby();
    logic [31:0] n;
    apb(1'b0, step_seq_pkg::STEP_COUNT_OFS, '0, n, err);
    u_host.drive_sel(3'b000, 70);
    stat();
    `CHK({st[9:8], osc, a_oe, b_oe}, 5'h00)
    u_host.pulse_step(1'b1);
    u_host.drive_sel(3'b111, 60);
    u_host.pulse_step(1'b1);
    u_host.wake(3'b111);
    apb(1'b0, step_seq_pkg::STEP_COUNT_OFS, '0, st, err);
    `CHK(st[15:0], n[15:0])
    stat();
    `CHK({st[9:8], st[6:0]}, {2'h2, 7'h11})
    u_host.pulse_step(1'b1);
    apb(1'b0, step_seq_pkg::STEP_COUNT_OFS, '0, st, err);
    `CHK(st[15:0], n[15:0] + 16'h0001)
  endtask : t_standby

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    rst_n_in   <= 1'b0;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    pwrite_in  <= 1'b0;
    paddr_in   <= '0;
    pwdata_in  <= '0;
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_run();
    t_res_table();
    t_nearest_and_filter();
    t_standby();
    give_verdict();
  end
endmodule : step_clock_sequencer_tb
